//--- hdl/gpc_pkg.sv
// shared constants and types for the pin configuration register block
package gpc_pkg;

  // which port instance this block sits in; masks and reset values follow it
  typedef enum logic [1:0] {
    GPC_PORT_A = 2'h0,
    GPC_PORT_B = 2'h1,
    GPC_PORT_C = 2'h2,
    GPC_PORT_F = 2'h3
  } gpc_port_type;

  // register byte offsets
  localparam logic [7:0] GPC_OFS_MODE = 8'h00;
  localparam logic [7:0] GPC_OFS_OKIND = 8'h04;
  localparam logic [7:0] GPC_OFS_EDGE = 8'h08;

  // two-bit pin function encodings
  localparam logic [1:0] GPC_FN_INPUT = 2'h0;
  localparam logic [1:0] GPC_FN_OUTPUT = 2'h1;
  localparam logic [1:0] GPC_FN_ALTERNATE = 2'h2;
  localparam logic [1:0] GPC_FN_ANALOG = 2'h3;

  // field geometry
  localparam int GPC_PINS = 16;
  localparam int GPC_FN_W = 2;
  localparam int GPC_PER_PIN_LSB = 0;
  localparam int GPC_PER_PIN_MSB = 15;

  // mode register reset values per port
  localparam logic [31:0] GPC_MODE_RST_A = 32'hebffffff;
  localparam logic [31:0] GPC_MODE_RST_B = 32'hffffffff;
  localparam logic [31:0] GPC_MODE_RST_C = 32'hfc000000;
  localparam logic [31:0] GPC_MODE_RST_F = 32'h0000f03f;

  // output kind register resets to zero on every port
  localparam logic [31:0] GPC_OKIND_RST = 32'h00000000;

  // edge speed register reset values per port
  localparam logic [31:0] GPC_EDGE_RST_AB = 32'h0000ffff;
  localparam logic [31:0] GPC_EDGE_RST_C = 32'h0000e000;
  localparam logic [31:0] GPC_EDGE_RST_F = 32'h000000c7;

  // implemented-bit masks of the two-bit mode register
  localparam logic [31:0] GPC_MODE_MASK_AB = 32'hffffffff;
  localparam logic [31:0] GPC_MODE_MASK_C = 32'hfc000000;
  localparam logic [31:0] GPC_MODE_MASK_F = 32'h0000f03f;

  // implemented-bit masks of the one-bit-per-pin registers
  localparam logic [31:0] GPC_PIN_MASK_AB = 32'h0000ffff;
  localparam logic [31:0] GPC_PIN_MASK_C = 32'h0000e000;
  localparam logic [31:0] GPC_PIN_MASK_F = 32'h000000c7;

  // value returned for unmapped reads and idle cycles
  localparam logic [31:0] GPC_RD_IDLE = 32'h00000000;

  // bus write request travelling as one bundle
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [31:0] data;
  } gpc_wr_type;

endpackage

//--- hdl/gpc_cfg_reg.sv
`timescale 1ns/1ps
`default_nettype none
// one 32-bit configuration register with a mask of implemented bits
module gpc_cfg_reg import gpc_pkg::*; #(
  parameter logic [31:0] RST_VAL = 32'h00000000,
  parameter logic [31:0] IMPL_MASK = 32'hffffffff
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  output logic [31:0] value_q
);

  // whole state of the register
  typedef struct packed {
    logic [31:0] value;
  } gpc_cfg_state_type;

  gpc_cfg_state_type state_q; // registered state
  gpc_cfg_state_type state_d; // next state

  // next value: implemented bits follow the write, reserved bits keep reset value
  always_comb begin
    state_d = state_q;
    if (wr_en) begin
      state_d.value = (wr_data & IMPL_MASK) | (RST_VAL & ~IMPL_MASK);
    end
  end

  // register the state; synchronous reset loads the port's reset value
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= '{value: RST_VAL};
    end else begin
      state_q <= state_d;
    end
  end

  // straight from the flop
  assign value_q = state_q.value;

endmodule
`default_nettype wire

//--- hdl/gpc_pin_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - two-bit function per pin, pin y at 2y+1:2y
// - mode register resets to port-specific value
// - only the port's existing pins are writable
// - upper sixteen bits of kind/edge stay fixed
// - one open-drain select bit per pin
// - output kind register resets to zero
// - one slow-edge select bit per pin
// - edge register resets to port-specific value
module gpc_pin_config_regs import gpc_pkg::*; #(
  parameter gpc_port_type PORT = GPC_PORT_A
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [31:0] pin_function_field,
  output logic [15:0] open_drain_select,
  output logic [15:0] slow_edge_select
);

  // per-port reset values and implemented masks, picked at elaboration
  localparam logic [31:0] MODE_RST = (PORT == GPC_PORT_A) ? GPC_MODE_RST_A :
                                     (PORT == GPC_PORT_B) ? GPC_MODE_RST_B :
                                     (PORT == GPC_PORT_C) ? GPC_MODE_RST_C : GPC_MODE_RST_F;
  localparam logic [31:0] MODE_MASK = (PORT == GPC_PORT_C) ? GPC_MODE_MASK_C :
                                      (PORT == GPC_PORT_F) ? GPC_MODE_MASK_F : GPC_MODE_MASK_AB;
  localparam logic [31:0] PIN_MASK = (PORT == GPC_PORT_C) ? GPC_PIN_MASK_C :
                                     (PORT == GPC_PORT_F) ? GPC_PIN_MASK_F : GPC_PIN_MASK_AB;
  localparam logic [31:0] EDGE_RST = (PORT == GPC_PORT_C) ? GPC_EDGE_RST_C :
                                     (PORT == GPC_PORT_F) ? GPC_EDGE_RST_F : GPC_EDGE_RST_AB;

  // bus request bundle
  gpc_wr_type wr_req;

  // decoded write enables, one per register
  logic wr_mode;
  logic wr_okind;
  logic wr_edge;

  // current register contents from the three register cells
  logic [31:0] mode_val;
  logic [31:0] okind_val;
  logic [31:0] edge_val;

  // next pad control values, one slice per pin, filled by the per-pin loop below
  logic [31:0] fn_next;
  logic [15:0] od_next;
  logic [15:0] slow_next;

  // whole registered state of this module: read data and pad controls
  typedef struct packed {
    logic [31:0] rdata;
    logic [31:0] fn;
    logic [15:0] od;
    logic [15:0] slow;
  } gpc_top_state_type;

  gpc_top_state_type state_q; // registered state
  gpc_top_state_type state_d; // next state

  // gather the write strobe with its address and data
  assign wr_req = '{en: reg_wr, addr: reg_addr, data: reg_wdata};

  // address decode for writes; unmapped addresses write nothing
  assign wr_mode = wr_req.en && (wr_req.addr == GPC_OFS_MODE);
  assign wr_okind = wr_req.en && (wr_req.addr == GPC_OFS_OKIND);
  assign wr_edge = wr_req.en && (wr_req.addr == GPC_OFS_EDGE);

  // mode register: two bits per pin, reserved pins hold their reset code
  gpc_cfg_reg #(
    .RST_VAL(MODE_RST),
    .IMPL_MASK(MODE_MASK)
  ) u_mode (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_mode),
    .wr_data(wr_req.data),
    .value_q(mode_val)
  );

  // output kind register: zero push-pull, one open-drain, upper half fixed
  gpc_cfg_reg #(
    .RST_VAL(GPC_OKIND_RST),
    .IMPL_MASK(PIN_MASK)
  ) u_okind (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_okind),
    .wr_data(wr_req.data),
    .value_q(okind_val)
  );

  // edge speed register: zero fast, one slow, upper half fixed
  gpc_cfg_reg #(
    .RST_VAL(EDGE_RST),
    .IMPL_MASK(PIN_MASK)
  ) u_edge (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_edge),
    .wr_data(wr_req.data),
    .value_q(edge_val)
  );

  // per-pin pad control; an implemented pin follows its register, a reserved pin never moves
  // the masks are fixed at elaboration, so a reserved pin costs no logic at all
  for (genvar y = 0; y < GPC_PINS; y++) begin : g_pin
    // this pin exists on the port when its one-bit mask is set
    localparam bit PIN_IMPL = PIN_MASK[y];
    // reset codes of this pin in each register
    localparam logic [1:0] FN_RST = MODE_RST[2*y +: 2];
    localparam logic OD_RST = GPC_OKIND_RST[y];
    localparam logic SLOW_RST = EDGE_RST[y];

    if (PIN_IMPL) begin : g_impl
      // function field: the write value on a mode write, the stored value otherwise
      assign fn_next[2*y +: 2] = wr_mode ? wr_req.data[2*y +: 2] : mode_val[2*y +: 2];
      // open-drain select: zero push-pull, one open-drain
      assign od_next[y] = wr_okind ? wr_req.data[y] : okind_val[y];
      // slow-edge select: zero fast, one slow
      assign slow_next[y] = wr_edge ? wr_req.data[y] : edge_val[y];

      // a mode write lands on this pin's function pads one edge later
      AST_PIN_FN_WRITE: assert property (@(posedge clk) disable iff (rst)
        wr_mode |=> pin_function_field[2*y +: 2] == $past(reg_wdata[2*y +: 2]))
        else $error("pin function pads missed a mode write");

      // the open-drain and slow-edge pads of this pin hold without a write to their register
      // a glitch here would flip the driver kind of a live output
      AST_PIN_OD_HOLD: assert property (@(posedge clk) disable iff (rst)
        !wr_okind |=> open_drain_select[y] == $past(okind_val[y]))
        else $error("open-drain pad moved without a kind write");
      AST_PIN_SLOW_HOLD: assert property (@(posedge clk) disable iff (rst)
        !wr_edge |=> slow_edge_select[y] == $past(edge_val[y]))
        else $error("slow-edge pad moved without an edge write");
    end else begin : g_resv
      // reserved pin: its pads carry the reset code forever, writes never reach them
      assign fn_next[2*y +: 2] = FN_RST;
      assign od_next[y] = OD_RST;
      assign slow_next[y] = SLOW_RST;

      // a reserved pin's pads never leave the reset code, whatever software writes
      AST_PIN_RESV_FIXED: assert property (@(posedge clk) disable iff (rst)
        pin_function_field[2*y +: 2] == FN_RST && open_drain_select[y] == OD_RST
        && slow_edge_select[y] == SLOW_RST)
        else $error("reserved pin pads left their reset code");
    end
  end

  // next state: read mux and pad control copies
  always_comb begin
    state_d = state_q;
    // read data stand only in the cycle after the strobe
    state_d.rdata = GPC_RD_IDLE;
    if (reg_rd) begin
      unique case (reg_addr)
        GPC_OFS_MODE: begin
          state_d.rdata = mode_val;
        end
        GPC_OFS_OKIND: begin
          state_d.rdata = okind_val;
        end
        GPC_OFS_EDGE: begin
          state_d.rdata = edge_val;
        end
        default: begin
          state_d.rdata = GPC_RD_IDLE; // unmapped reads return zero
        end
      endcase
    end
    // pad controls track the value a write is storing this very edge, so pads and
    // register cells never disagree for a cycle; the per-pin slices pick write or hold
    state_d.fn = fn_next;
    state_d.od = od_next;
    state_d.slow = slow_next;
  end

  // register the state; pad controls take the reset values with the registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= '{rdata: GPC_RD_IDLE, fn: MODE_RST, od: GPC_OKIND_RST[15:0], slow: EDGE_RST[15:0]};
    end else begin
      state_q <= state_d;
    end
  end

  // every output straight from a flop
  assign reg_rdata = state_q.rdata;
  assign pin_function_field = state_q.fn;
  assign open_drain_select = state_q.od;
  assign slow_edge_select = state_q.slow;

  // checks share one clock and the synchronous reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // after reset the mode pins show the port's reset code
  AST_MODE_RESET: assert property (disable iff (1'b0) rst |=> pin_function_field == MODE_RST)
    else $error("mode pads not at reset value after reset");

  // after reset every pin is push-pull
  AST_OKIND_RESET: assert property (disable iff (1'b0) rst |=> open_drain_select == 16'h0000)
    else $error("open-drain selects not zero after reset");

  // after reset the edge selects show the port's reset code
  AST_EDGE_RESET: assert property (disable iff (1'b0) rst |=> slow_edge_select == EDGE_RST[15:0])
    else $error("slow-edge selects not at reset value after reset");

  // a mode write reaches the pad controls of implemented pins on the next edge
  AST_MODE_WRITE: assert property (wr_mode |=> (pin_function_field & MODE_MASK)
                                    == ($past(reg_wdata) & MODE_MASK))
    else $error("mode write did not reach the pad controls");

  // reserved mode fields never move away from their reset code
  AST_MODE_RESV: assert property ((pin_function_field & ~MODE_MASK) == (MODE_RST & ~MODE_MASK))
    else $error("reserved mode field changed");

  // kind write reaches open-drain selects; reserved pins stay push-pull
  AST_OKIND_WRITE: assert property (wr_okind |=> open_drain_select
                                     == ($past(reg_wdata[15:0]) & PIN_MASK[15:0]))
    else $error("output kind write did not reach the pads");

  // edge write reaches slow-edge selects on implemented pins
  AST_EDGE_WRITE: assert property (wr_edge |=> (slow_edge_select & PIN_MASK[15:0])
                                    == ($past(reg_wdata[15:0]) & PIN_MASK[15:0]))
    else $error("edge write did not reach the pads");

  // upper half of kind and edge reads as zero even after writing ones
  AST_UPPER_ZERO: assert property (reg_rd && (reg_addr == GPC_OFS_OKIND || reg_addr == GPC_OFS_EDGE)
                                    |=> reg_rdata[31:16] == 16'h0000)
    else $error("reserved upper half read back non-zero");

  // without a write the pad controls stay put for two cycles
  AST_PADS_HOLD: assert property (!reg_wr ##1 !reg_wr |=> $stable(pin_function_field)
                                   && $stable(open_drain_select) && $stable(slow_edge_select))
    else $error("pad controls moved without a write");

  // a mode read returns what the pads are being driven with
  AST_READ_MATCH: assert property (reg_rd && reg_addr == GPC_OFS_MODE |=> reg_rdata == $past(pin_function_field))
    else $error("mode read differs from pad controls");

  // read data are zero in any cycle not following a read strobe
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == GPC_RD_IDLE)
    else $error("read data present without a read");

  // a kind read returns the open-drain pads in the low half and the fixed upper half
  // software can rely on this to see exactly what the pads are driven with
  AST_READ_OKIND: assert property (reg_rd && reg_addr == GPC_OFS_OKIND
                                    |=> reg_rdata == {GPC_OKIND_RST[31:16], $past(open_drain_select)})
    else $error("kind read differs from open-drain pads");

  // an edge read returns the slow-edge pads in the low half and the fixed upper half
  AST_READ_EDGE: assert property (reg_rd && reg_addr == GPC_OFS_EDGE
                                   |=> reg_rdata == {EDGE_RST[31:16], $past(slow_edge_select)})
    else $error("edge read differs from slow-edge pads");

  // a read of an unmapped address answers with the idle value
  AST_READ_UNMAPPED: assert property (reg_rd && reg_addr != GPC_OFS_MODE && reg_addr != GPC_OFS_OKIND
                                       && reg_addr != GPC_OFS_EDGE |=> reg_rdata == GPC_RD_IDLE)
    else $error("unmapped read returned data");

  // a mode write leaves the driver kind and edge speed pads alone
  AST_MODE_WRITE_ONLY: assert property (wr_mode |=> $stable(open_drain_select)
                                         && $stable(slow_edge_select))
    else $error("mode write disturbed other pads");

  // a kind write leaves the function and edge speed pads alone
  AST_OKIND_WRITE_ONLY: assert property (wr_okind |=> $stable(pin_function_field)
                                          && $stable(slow_edge_select))
    else $error("kind write disturbed other pads");

  // an edge write leaves the function and driver kind pads alone
  AST_EDGE_WRITE_ONLY: assert property (wr_edge |=> $stable(pin_function_field)
                                         && $stable(open_drain_select))
    else $error("edge write disturbed other pads");

  // a write to an unmapped address changes no pad at all
  // a stray write must never reconfigure a live pin
  AST_UNMAPPED_WRITE: assert property (reg_wr && reg_addr != GPC_OFS_MODE && reg_addr != GPC_OFS_OKIND
                                        && reg_addr != GPC_OFS_EDGE |=> $stable(pin_function_field)
                                        && $stable(open_drain_select) && $stable(slow_edge_select))
    else $error("unmapped write moved a pad");

  // missing pins never show open-drain, whatever the kind register was given
  AST_OKIND_RESV_ZERO: assert property ((open_drain_select & ~PIN_MASK[15:0]) == 16'h0000)
    else $error("missing pin shows open-drain");

  // missing pins keep the edge reset code
  // the pad ring of a missing pin may still exist, so its setting must not drift
  AST_EDGE_RESV_FIXED: assert property ((slow_edge_select & ~PIN_MASK[15:0])
                                         == (EDGE_RST[15:0] & ~PIN_MASK[15:0]))
    else $error("missing pin edge select changed");

endmodule
`default_nettype wire

//--- tb/gpc_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
// pad cell stand-in: turns configuration outputs into per-pin driver states
module gpc_pad_model import gpc_pkg::*; (
  input wire logic [31:0] pin_function_field,
  input wire logic [15:0] open_drain_select,
  input wire logic [15:0] slow_edge_select,
  output logic [15:0] pad_push_pull,
  output logic [15:0] pad_slow
);
  // a pin drives both levels only in output or alternate mode with push-pull kind
  always_comb begin
    for (int y = 0; y < GPC_PINS; y++) begin
      pad_push_pull[y] = (pin_function_field[2*y +: 2] inside {GPC_FN_OUTPUT, GPC_FN_ALTERNATE})
        && !open_drain_select[y];
      pad_slow[y] = slow_edge_select[y];
    end
  end
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
// four port instances share one bus; a reference model follows every access
module tb import gpc_pkg::*;;
  localparam logic [31:0] MODE_RST [4] = '{GPC_MODE_RST_A, GPC_MODE_RST_B, GPC_MODE_RST_C, GPC_MODE_RST_F};
  localparam logic [31:0] MODE_MASK [4] = '{GPC_MODE_MASK_AB, GPC_MODE_MASK_AB, GPC_MODE_MASK_C, GPC_MODE_MASK_F};
  localparam logic [31:0] PIN_MASK [4] = '{GPC_PIN_MASK_AB, GPC_PIN_MASK_AB, GPC_PIN_MASK_C, GPC_PIN_MASK_F};
  localparam logic [31:0] EDGE_RST [4] = '{GPC_EDGE_RST_AB, GPC_EDGE_RST_AB, GPC_EDGE_RST_C, GPC_EDGE_RST_F};
  logic clk, rst, reg_wr, reg_rd; // shared bus controls
  logic [7:0] reg_addr; // shared address
  logic [31:0] reg_wdata; // shared write data
  logic [31:0] rdata [4]; // read data per port
  logic [31:0] fn [4]; // pin functions per port
  logic [15:0] od [4]; // open-drain selects per port
  logic [15:0] se [4]; // slow-edge selects per port
  logic [15:0] push_a, slow_a; // pad model view of port a
  logic [31:0] m_mode [4], m_kind [4], m_edge [4], m_rd [4]; // reference registers
  logic [15:0] exp_push; // expected push-pull pins of port a
  logic rd_pend; // a read answer is due this cycle
  int miscompares, num_checks;
  // one instance per port kind
  for (genvar p = 0; p < 4; p++) begin : g_port
    gpc_pin_config_regs #(.PORT(gpc_port_type'(p))) dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata[p]),
      .pin_function_field(fn[p]), .open_drain_select(od[p]), .slow_edge_select(se[p]));
  end
  // pad cells hang off port a
  gpc_pad_model pads (.pin_function_field(fn[0]), .open_drain_select(od[0]), .slow_edge_select(se[0]),
    .pad_push_pull(push_a), .pad_slow(slow_a));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus cycle; the next call replaces every signal, so strobes may follow back to back
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask
  // verdict and end of run
  task automatic summarize;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // reference model: compare pre-edge outputs, then take this edge's request
  always @(posedge clk) begin
    for (int p = 0; p < 4; p++) begin
      if (rst) begin
        m_mode[p] = MODE_RST[p];
        m_kind[p] = GPC_OKIND_RST;
        m_edge[p] = EDGE_RST[p];
      end else begin
        check(rdata[p], rd_pend ? m_rd[p] : GPC_RD_IDLE);
        check(fn[p], m_mode[p]);
        check({od[p], se[p]}, {m_kind[p][15:0], m_edge[p][15:0]});
        m_rd[p] = reg_addr == GPC_OFS_MODE ? m_mode[p] : reg_addr == GPC_OFS_OKIND ? m_kind[p] :
          reg_addr == GPC_OFS_EDGE ? m_edge[p] : GPC_RD_IDLE;
        // reserved bits keep their reset value
        if (reg_wr && reg_addr == GPC_OFS_MODE) m_mode[p] = m_mode[p] & ~MODE_MASK[p] | reg_wdata & MODE_MASK[p];
        if (reg_wr && reg_addr == GPC_OFS_OKIND) m_kind[p] = m_kind[p] & ~PIN_MASK[p] | reg_wdata & PIN_MASK[p];
        if (reg_wr && reg_addr == GPC_OFS_EDGE) m_edge[p] = m_edge[p] & ~PIN_MASK[p] | reg_wdata & PIN_MASK[p];
      end
    end
    // push-pull drive needs function 01 or 10 and kind 0
    for (int y = 0; y < 16; y++) exp_push[y] = (fn[0][2*y] ^ fn[0][2*y+1]) & ~od[0][y];
    if (!rst) check({push_a, slow_a}, {exp_push, se[0]});
    rd_pend = !rst && reg_rd;
  end
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    summarize();
  end
  // main sequence
  initial begin
    logic [31:0] r;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    rd_pend = 1'b0;
    miscompares = 0;
    num_checks = 0;
    void'($urandom(52214));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // reset values and an unmapped read
    for (int i = 0; i < 4; i++) op(1'b0, 1'b1, 8'(4 * i), 32'h00000000);
    // all ones then all zeros, back to back, reserved bits must hold
    for (int v = 0; v < 2; v++) begin
      for (int i = 0; i < 4; i++) op(1'b1, 1'b0, 8'(4 * i), v ? 32'h00000000 : 32'hffffffff);
      for (int i = 0; i < 4; i++) op(1'b0, 1'b1, 8'(4 * i), 32'h00000000);
    end
    // every function code on every pin
    for (int c = 0; c < 4; c++) begin
      op(1'b1, 1'b0, GPC_OFS_MODE, {16{2'(c)}});
      op(1'b0, 1'b1, GPC_OFS_MODE, 32'h00000000);
    end
    // random traffic, including stray addresses
    for (int i = 0; i < 200; i++) begin
      r = $urandom;
      op(r[0], !r[0], r[4] ? r[15:8] : 8'(4 * r[3:2]), $urandom);
    end
    // reset in mid-run brings every register back
    rst <= 1'b1;
    op(1'b0, 1'b0, 8'h00, 32'h00000000);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) op(1'b0, 1'b1, 8'(4 * i), 32'h00000000);
    op(1'b0, 1'b0, 8'h00, 32'h00000000);
    op(1'b0, 1'b0, 8'h00, 32'h00000000);
    summarize();
  end
endmodule
`default_nettype wire
